// >>> design/hisel_defines.vh
// Purpose: constants for the host interface select block
// Assumes: included by bare name from design files
// Notes:   protocol codes and synchroniser depth
`ifndef HISEL_DEFINES_VH
`define HISEL_DEFINES_VH
`define HISEL_PROTO_SPI      1'b0
`define HISEL_PROTO_I2C      1'b1
`define HISEL_SYNC_STAGES    3
`define HISEL_ADDR_LSB_RST   1'b0
`define HISEL_ADDR_BIT1_RST  1'b1
`define HISEL_THREE_WIRE_RST 1'b0
`endif

// >>> design/hisel_sync.v
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: d_i is asynchronous to sys_clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`include "hisel_defines.vh"
module hisel_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire sys_clk_i, // system clock
  input  wire rst_i,     // async reset, active high
  input  wire d_i,       // raw pin level
  output reg  q_o        // filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  ////////////////////////////////////////////////////////////////
  // three stage flops plus the output flop, level changes once stages two and three agree
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule

// >>> design/hisel_top.v
// Purpose: host protocol select and shared pin mapping for both sensor parts
// Assumes: all pins are asynchronous to sys_clk_i and pass the synchroniser
// Notes:   three-wire enables come from the register files of each part
`timescale 1ns/100ps
`include "hisel_defines.vh"
module hisel_top (
  input  wire sys_clk_i,                 // system clock, 25 MHz
  input  wire rst_i,                     // async reset, active high
  input  wire protocol_select_pin_i,     // 0 spi, 1 i2c
  input  wire chip_select_low_pin_i,     // chip select low / addr bit 1
  input  wire sck_pin_i,                 // serial clock pin
  input  wire sdi_pin_i,                 // serial data in / sda pin level
  input  wire sdo_pin_i,                 // sdo pin level, strap in i2c
  input  wire accel_three_wire_enable_i, // accel three-wire bit
  input  wire mag_three_wire_enable_i,   // mag three-wire bit
  input  wire mag_power_on_i,            // mag power control bit
  input  wire spi_sdo_data_i,            // spi read data from engines
  input  wire spi_sdo_drive_i,           // spi engine drives read data
  input  wire i2c_sda_low_i,             // i2c engine pulls sda low
  output reg  i2c_mode_o,                // 1 i2c engine active
  output reg  spi_sel_o,                 // spi engines selected
  output reg  spi_sck_o,                 // clock to spi engines
  output reg  i2c_scl_o,                 // clock to i2c engine
  output reg  spi_mosi_o,                // spi data into engines
  output reg  i2c_sda_o,                 // sda level to i2c engine
  output reg  accel_three_wire_o,        // accel spi three-wire active
  output reg  mag_three_wire_o,          // mag spi three-wire active
  output reg  addr_lsb_o,                // i2c addr bit 0, both parts
  output reg  mag_addr_bit1_o,           // i2c addr bit 1, mag part
  output reg  sdo_pin_o,                 // sdo pin data
  output reg  sdo_pin_oe_n_o,            // sdo pin enable, low drives
  output reg  sdi_pin_o,                 // sdi pin data
  output reg  sdi_pin_oe_n_o             // sdi pin enable, low drives
);

  ////////////////////////////////////////////////////////////////
  // pin indices into the synchroniser bank
  localparam NUM_PINS = 5;
  localparam PIN_PS   = 0;
  localparam PIN_CSB  = 1;
  localparam PIN_SCK  = 2;
  localparam PIN_SDI  = 3;
  localparam PIN_SDO  = 4;
  // reset level per pin: chip select idles inactive, the rest low
  localparam [NUM_PINS-1:0] PIN_RST = 5'h02;

  ////////////////////////////////////////////////////////////////
  // filtered pin levels and derived mode
  wire [NUM_PINS-1:0] pin_raw;    // raw pins, async
  wire [NUM_PINS-1:0] pin_s;      // pins after synchroniser
  wire                ps_s;       // protocol select level
  wire                csb_s;      // chip select level
  wire                sck_s;      // serial clock level
  wire                sdi_s;      // serial data in level
  wire                sdo_s;      // sdo strap level
  wire                spi_mode;   // 1 spi engines own the pins
  wire                three_wire; // sdi pin turns around
  wire                cs_act;     // spi chip select active
  reg                 accel_3w_q; // accel three-wire state
  reg                 mag_3w_q;   // mag three-wire state

  ////////////////////////////////////////////////////////////////
  // protocol decode: one select level for both parts
  function is_spi;
    input ps_level; // synchronised select
    begin
      is_spi = (ps_level == `HISEL_PROTO_SPI);
    end
  endfunction

  // shared-pin steering: selected side sees the pin, the other its idle
  function steer;
    input side_sel; // 1 this side owns the pin
    input pin_lvl;  // synchronised pin level
    input idle_lvl; // level shown while the side is unselected
    begin
      steer = side_sel ? pin_lvl : idle_lvl;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin synchronisers, one per shared pin
  assign pin_raw[PIN_PS]  = protocol_select_pin_i;
  assign pin_raw[PIN_CSB] = chip_select_low_pin_i;
  assign pin_raw[PIN_SCK] = sck_pin_i;
  assign pin_raw[PIN_SDI] = sdi_pin_i;
  assign pin_raw[PIN_SDO] = sdo_pin_i;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
      hisel_sync #(
        .RST_VAL (PIN_RST[g])
      ) i_hisel_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       (pin_raw[g]),
        .q_o       (pin_s[g])
      );
    end
  endgenerate

  // named taps on the filtered bank
  assign ps_s  = pin_s[PIN_PS];
  assign csb_s = pin_s[PIN_CSB];
  assign sck_s = pin_s[PIN_SCK];
  assign sdi_s = pin_s[PIN_SDI];
  assign sdo_s = pin_s[PIN_SDO];

  ////////////////////////////////////////////////////////////////
  // one select for both parts; no per-part protocol exists
  assign spi_mode   = is_spi(ps_s);
  // the sdi pin is shared, so the accel bit decides its turnaround
  assign three_wire = spi_mode & accel_3w_q;
  // chip select enables both parts, only in spi
  assign cs_act     = spi_mode & ~csb_s;

  ////////////////////////////////////////////////////////////////
  // three-wire state per part, four-wire after reset
  // mag bit is honoured only while the mag part is powered
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accel_3w_q <= `HISEL_THREE_WIRE_RST;
      mag_3w_q   <= `HISEL_THREE_WIRE_RST;
    end else begin
      accel_3w_q <= accel_three_wire_enable_i;
      mag_3w_q   <= mag_three_wire_enable_i & mag_power_on_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // mode and chip select outputs
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      i2c_mode_o <= 1'b0;
      spi_sel_o  <= 1'b0;
    end else begin
      i2c_mode_o <= ~spi_mode;
      spi_sel_o  <= cs_act;
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared clock pin feeds whichever engine is selected
  // the idle engine sees its bus idle level, so no stray edges reach it
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_sck_o <= 1'b0;
      i2c_scl_o <= 1'b1;
    end else begin
      spi_sck_o <= steer(spi_mode, sck_s, 1'b0);
      i2c_scl_o <= steer(~spi_mode, sck_s, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared data-in pin: spi data in or i2c serial data
  // unselected side holds its idle level
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_mosi_o <= 1'b0;
      i2c_sda_o  <= 1'b1;
    end else begin
      spi_mosi_o <= steer(spi_mode, sdi_s, 1'b0);
      i2c_sda_o  <= steer(~spi_mode, sdi_s, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // three-wire flags to each part, cleared in i2c mode
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accel_three_wire_o <= 1'b0;
      mag_three_wire_o   <= 1'b0;
    end else begin
      accel_three_wire_o <= spi_mode & accel_3w_q;
      mag_three_wire_o   <= spi_mode & mag_3w_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // address straps, sampled only in i2c mode and held in spi
  // chip select strap moves the mag address only
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_lsb_o      <= `HISEL_ADDR_LSB_RST;
      mag_addr_bit1_o <= `HISEL_ADDR_BIT1_RST;
    end else begin
      if (!spi_mode) begin
        addr_lsb_o      <= sdo_s;
        mag_addr_bit1_o <= csb_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // sdo pin drives read data only in four-wire spi with cs active
  // released otherwise so the strap level can be read in i2c
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_pin_o      <= 1'b0;
      sdo_pin_oe_n_o <= 1'b1;
    end else begin
      sdo_pin_o      <= spi_sdo_data_i;
      sdo_pin_oe_n_o <= ~(cs_act & ~three_wire & spi_sdo_drive_i);
    end
  end

  ////////////////////////////////////////////////////////////////
  // sdi pin drives in three-wire spi, open drain low in i2c
  // never drives high in i2c; the bus pull-up gives the high level
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdi_pin_o      <= 1'b0;
      sdi_pin_oe_n_o <= 1'b1;
    end else begin
      if (spi_mode) begin
        sdi_pin_o      <= spi_sdo_data_i;
        sdi_pin_oe_n_o <= ~(three_wire & cs_act & spi_sdo_drive_i);
      end else begin
        sdi_pin_o      <= 1'b0;
        sdi_pin_oe_n_o <= ~i2c_sda_low_i;
      end
    end
  end

endmodule

// >>> dv/hisel_props.sv
// Purpose: routing checks on hisel_top
// Assumes: bound to hisel_top
// Notes:   pins settle within six edges
`timescale 1ns/100ps
module hisel_props (
  input wire sys_clk_i, rst_i, protocol_select_pin_i, chip_select_low_pin_i, // pins
  input wire sck_pin_i, sdo_pin_i, accel_three_wire_enable_i, i2c_sda_low_i, // inputs
  input wire i2c_mode_o, spi_sel_o, spi_sck_o, accel_three_wire_o, mag_three_wire_o, // out
  input wire addr_lsb_o, mag_addr_bit1_o, sdi_pin_o, sdi_pin_oe_n_o, sdo_pin_oe_n_o // out
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_mode_select: assert property (protocol_select_pin_i[*7] |-> i2c_mode_o)
    else $error("i2c mode missing");
  a_no_mix: assert property (i2c_mode_o |-> !spi_sel_o && !accel_three_wire_o && !mag_three_wire_o)
    else $error("spi active in i2c");
  a_four_wire: assert property (!accel_three_wire_enable_i[*3] |-> !accel_three_wire_o)
    else $error("three-wire unasked");
  a_three_wire: assert property ((accel_three_wire_enable_i && !i2c_mode_o)[*3] |-> accel_three_wire_o)
    else $error("three-wire missing");
  a_sdo_strap: assert property ((i2c_mode_o && sdo_pin_i)[*6] |-> addr_lsb_o && sdo_pin_oe_n_o)
    else $error("address lsb wrong");
  a_sda_pull: assert property (i2c_mode_o && i2c_sda_low_i |=> !sdi_pin_oe_n_o && !sdi_pin_o)
    else $error("sda not pulled");
  a_csb_strap: assert property ((i2c_mode_o && !chip_select_low_pin_i)[*6] |-> !mag_addr_bit1_o)
    else $error("address bit1 wrong");
  a_sck_route: assert property ((!i2c_mode_o && sck_pin_i)[*6] |-> spi_sck_o)
    else $error("spi clock lost");
  c_three: cover property (accel_three_wire_o && mag_three_wire_o);
  c_frame: cover property (spi_sel_o && spi_sck_o);
  c_sda: cover property (i2c_mode_o && !sdi_pin_oe_n_o);
endmodule
bind hisel_top hisel_props i_hisel_props (.*);

// >>> dv/hisel_host.sv
// Purpose: host master on the shared pins
// Assumes: clk_i is the bench clock
// Notes:   sck idles high, runs only in frames
`timescale 1ns/100ps
module hisel_host (
  input  wire clk_i,  // bench clock
  output reg  sck_o,  // serial clock pin
  output reg  sdi_o,  // data to device
  output reg  cs_n_o  // chip select, low active
);
  integer i;
  initial begin
    {sck_o, sdi_o, cs_n_o} = 3'h7;
  end
  // one mode 11 byte at 320 ns per bit
  task frame(input [7:0] b);
    begin
      cs_n_o = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        repeat (4) @(negedge clk_i);
        {sck_o, sdi_o} = {1'b0, b[i]};
        repeat (4) @(negedge clk_i);
        sck_o = 1'b1;
      end
      repeat (4) @(negedge clk_i);
      {cs_n_o, sdi_o} = {1'b1, ~sdi_o}; // released line shows no stale bit
    end
  endtask
endmodule

// >>> dv/hisel_bench.sv
// Purpose: bench for hisel_top
// Assumes: host model drives sck, sdi, csb
// Notes:   protocol select moves only in reset
`timescale 1ns/100ps
module hisel_bench;
  reg sys_clk_i, rst_i, ps, strap, b1v, a3, m3, pwr, dat, drv, sda_lo;
  integer error_cnt, num_checks;
  wire sck, sdi_h, csb_n, sdo_o, sdo_oe_n, sdi_o, sdi_oe_n, mode, sel, ssck, mosi, at, mt, lsb, b1;
  wire scl, isda;
  // pin levels from all drivers; sda pulled up in i2c
  wire sdi_w = !sdi_oe_n ? sdi_o : (ps ? 1'b1 : sdi_h);
  wire sdo_w = !sdo_oe_n ? sdo_o : strap;
  wire csb_w = ps ? b1v : csb_n;
  hisel_host i_hisel_host (.clk_i(sys_clk_i), .sck_o(sck), .sdi_o(sdi_h), .cs_n_o(csb_n));
  hisel_top i_hisel_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .protocol_select_pin_i(ps),
    .chip_select_low_pin_i(csb_w), .sck_pin_i(sck), .sdi_pin_i(sdi_w), .sdo_pin_i(sdo_w),
    .accel_three_wire_enable_i(a3), .mag_three_wire_enable_i(m3), .mag_power_on_i(pwr),
    .spi_sdo_data_i(dat), .spi_sdo_drive_i(drv), .i2c_sda_low_i(sda_lo), .i2c_mode_o(mode),
    .spi_sel_o(sel), .spi_sck_o(ssck), .i2c_scl_o(scl), .spi_mosi_o(mosi), .i2c_sda_o(isda),
    .accel_three_wire_o(at), .mag_three_wire_o(mt), .addr_lsb_o(lsb), .mag_addr_bit1_o(b1),
    .sdo_pin_o(sdo_o), .sdo_pin_oe_n_o(sdo_oe_n), .sdi_pin_o(sdi_o), .sdi_pin_oe_n_o(sdi_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task do_reset(input p);
    begin
      {rst_i, ps} = {1'b1, p}; // select moves only in reset
      cyc(10);
      rst_i = 1'b0;
      cyc(8);
    end
  endtask
  // four-wire frame with read data on sdo
  task t_spi;
    begin
      do_reset(1'b0);
      chk({mode, at, mt, sdo_oe_n, scl, isda}, 8'h07);
      fork
        i_hisel_host.frame(8'hA5);
        begin
          {drv, dat} = 2'b11;
          cyc(14);
          chk({sel, ssck, mosi, sdo_oe_n, sdo_o}, 8'h1D);
        end
      join
      cyc(8);
      chk({sel, sdo_oe_n}, 8'h01);
    end
  endtask
  // three-wire, mag gated by power bit, read on sdi
  task t_three;
    begin
      {a3, m3, pwr, dat} = 4'hC;
      cyc(4);
      chk({at, mt}, 8'h02);
      pwr = 1'b1;
      cyc(4);
      chk({at, mt}, 8'h03);
      fork
        i_hisel_host.frame(8'h3C);
        begin
          cyc(14);
          chk({sdi_oe_n, sdi_o, sdo_oe_n}, 8'h01);
        end
      join
      {a3, m3, drv} = 3'h0;
    end
  endtask
  // i2c straps, sda pull and blocked spi
  task t_i2c;
    begin
      {strap, b1v, a3} = 3'b101;
      do_reset(1'b1);
      chk({mode, sel, lsb, b1, sdo_oe_n, ssck, at}, 8'h54);
      chk({scl, isda}, 8'h03);
      sda_lo = 1'b1;
      cyc(2);
      chk({sdi_oe_n, sdi_o}, 8'h00);
      {sda_lo, strap, b1v} = 3'b001;
      cyc(8);
      chk({lsb, b1}, 8'h01);
    end
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {rst_i, ps, strap, b1v, a3, m3, pwr, dat, drv, sda_lo} = 10'h208;
    {error_cnt, num_checks} = 0;
    t_spi;
    t_three;
    t_i2c;
    complete_run;
  end
  // watchdog for a hung run
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
endmodule
